// ==== dv/tmr8_timer_tb.sv ====
// Purpose: self-checking bench for the 8-bit timer over APB
// Assumes: one wait state per APB access, registered pin and request outputs
// Notes:   PWM duty is judged over a 1020-cycle window with a small tolerance
`timescale 1ns/100ps
module tmr8_timer_tb
  import tmr8_pkg::*;
;
  logic          pclk;
  logic          presetn;
  tmr8_apb_req_s req;
  tmr8_apb_rsp_s rsp;
  logic          osc;
  logic          osc_run;
  logic          gie;
  logic          cack;
  logic          oack;
  logic          pdir;
  logic          pdat;
  tmr8_pin_s     pin;
  tmr8_irq_s     irq;
  int            fails;
  int            checks;
  logic [31:0]   rd;
  logic          err;

  tmr8_timer i_dut (
    .pclk                (pclk),
    .presetn             (presetn),
    .apb_req             (req),
    .apb_rsp             (rsp),
    .oscillator_input_pin(osc),
    .global_irq_enable   (gie),
    .compare_vector_ack  (cack),
    .overflow_vector_ack (oack),
    .port_direction_bit  (pdir),
    .port_data_bit       (pdat),
    .pin                 (pin),
    .irq                 (irq)
  );

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Period unrelated to pclk; stands still while osc_run is low
  initial
  begin
    osc = 1'b0;
    forever
    begin
      #37;
      if (osc_run) osc = ~osc;
    end
  end

  task automatic tally_and_finish;
    if (fails == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : tally_and_finish

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc

  task automatic apb(input logic wr, input logic [5:0] idx,
                     input logic [7:0] wd);
    int n;
    @(posedge pclk);
    req.psel    <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite  <= wr;
    req.paddr   <= {4'h0, idx, 2'b00};
    req.pwdata  <= {24'h000000, wd};
    @(posedge pclk);
    req.penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
      if (n > 20)
      begin
        fails++;
        tally_and_finish();
      end
    end while (rsp.pready !== 1'b1);
    rd  = rsp.prdata;
    err = rsp.pslverr;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask : wr

  task automatic rdc(input logic [5:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    check(rd, {24'h000000, exp});
  endtask : rdc

  function automatic logic [7:0] ctl(input logic f, input logic [1:0] m,
                                     input logic [1:0] com,
                                     input logic [2:0] cs);
    return {f, m[0], com, m[1], cs};
  endfunction : ctl

  task automatic wait_irq(input logic cmp);
    int n;
    n = 0;
    while ((cmp ? irq.cmp_req : irq.ovf_req) !== 1'b1)
    begin
      @(posedge pclk);
      n++;
      if (n > 600)
      begin
        fails++;
        tally_and_finish();
      end
    end
  endtask : wait_irq

  task automatic t_regs;
    rdc(IDX_CONTROL, 8'h00);
    rdc(IDX_COUNT, 8'h00);
    rdc(IDX_COMPARE, 8'h00);
    rdc(IDX_MASK, 8'h00);
    rdc(IDX_FLAGS, 8'h00);
    wr(IDX_COUNT, 8'h5A);
    rdc(IDX_COUNT, 8'h5A);
    wr(IDX_COMPARE, 8'hA5);
    rdc(IDX_COMPARE, 8'hA5);
    wr(IDX_MASK, 8'h03);
    rdc(IDX_MASK, 8'h03);
    wr(IDX_MASK, 8'h00);
    apb(1'b0, 6'h15, 8'h00);
    check(err, 1'b1);
  endtask : t_regs

  task automatic t_force;
    logic [1:0] com [4] = '{COM_SET, COM_CLEAR, COM_TOGGLE, COM_TOGGLE};
    logic       exp [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    wr(IDX_COMPARE, 8'h05);
    wr(IDX_COUNT, 8'h05);
    pdir <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      wr(IDX_CONTROL, ctl(1'b1, WM_CTC, com[i], CS_STOP));
      cyc(4);
      check(pin.out, exp[i]);
    end
    check(pin.override, 1'b1);
    check(pin.oe, 1'b1);
    rdc(IDX_CONTROL, ctl(1'b0, WM_CTC, COM_TOGGLE, CS_STOP));
    rdc(IDX_COUNT, 8'h05);
    rdc(IDX_FLAGS, 8'h00);
    // PWM writes keep the strobe at zero; the mode switch alone is silent
    wr(IDX_CONTROL, ctl(1'b0, WM_FAST, COM_SET, CS_STOP));
    cyc(4);
    check(pin.out, 1'b0);
    wr(IDX_CONTROL, ctl(1'b0, WM_NORMAL, COM_OFF, CS_STOP));
    pdat <= 1'b1;
    pdir <= 1'b0;
    cyc(3);
    check(pin.override, 1'b0);
    check(pin.out, 1'b1);
    check(pin.oe, 1'b0);
  endtask : t_force

  task automatic t_ovf;
    wr(IDX_COMPARE, 8'h80);
    wr(IDX_FLAGS, 8'h03);
    wr(IDX_MASK, 8'h01);
    gie <= 1'b1;
    wr(IDX_COUNT, 8'hF0);
    wr(IDX_CONTROL, ctl(1'b0, WM_NORMAL, COM_OFF, CS_1));
    wait_irq(1'b0);
    wr(IDX_CONTROL, ctl(1'b0, WM_NORMAL, COM_OFF, CS_STOP));
    rdc(IDX_FLAGS, 8'h01);
    apb(1'b0, IDX_COUNT, 8'h00);
    check(rd < 32'h10, 1'b1);
    gie <= 1'b0;
    cyc(3);
    check(irq.ovf_req, 1'b0);
    gie <= 1'b1;
    cyc(3);
    check(irq.ovf_req, 1'b1);
    oack <= 1'b1;
    @(posedge pclk);
    oack <= 1'b0;
    cyc(3);
    check(irq.ovf_req, 1'b0);
    rdc(IDX_FLAGS, 8'h00);
  endtask : t_ovf

  task automatic t_ctc;
    wr(IDX_COMPARE, 8'h10);
    wr(IDX_COUNT, 8'h00);
    wr(IDX_MASK, 8'h02);
    wr(IDX_CONTROL, ctl(1'b0, WM_CTC, COM_OFF, CS_1));
    wait_irq(1'b1);
    apb(1'b0, IDX_COUNT, 8'h00);
    check(rd <= 32'h10, 1'b1);
    wr(IDX_CONTROL, ctl(1'b0, WM_CTC, COM_OFF, CS_STOP));
    // Counter never passes the compare value, so no overflow either
    rdc(IDX_FLAGS, 8'h02);
    check(irq.cmp_req, 1'b1);
    cack <= 1'b1;
    @(posedge pclk);
    cack <= 1'b0;
    cyc(3);
    check(irq.cmp_req, 1'b0);
    rdc(IDX_FLAGS, 8'h00);
    wr(IDX_CONTROL, ctl(1'b0, WM_CTC, COM_OFF, CS_1));
    wait_irq(1'b1);
    wr(IDX_CONTROL, ctl(1'b0, WM_CTC, COM_OFF, CS_STOP));
    wr(IDX_FLAGS, 8'h02);
    cyc(3);
    check(irq.cmp_req, 1'b0);
    rdc(IDX_FLAGS, 8'h00);
    wr(IDX_MASK, 8'h00);
  endtask : t_ctc

  task automatic t_block;
    wr(IDX_COMPARE, 8'h40);
    wr(IDX_COUNT, 8'h30);
    wr(IDX_CONTROL, ctl(1'b0, WM_NORMAL, COM_OFF, CS_1));
    // Running write on purpose; only a missed match may follow
    wr(IDX_COUNT, 8'h40);
    cyc(8);
    rdc(IDX_FLAGS, 8'h00);
    wr(IDX_CONTROL, ctl(1'b0, WM_NORMAL, COM_OFF, CS_STOP));
  endtask : t_block

  task automatic t_presc;
    int lo [8] = '{0, 6, 4, 4, 4, 4, 4, 4};
    int hi [8] = '{0, 8, 5, 5, 5, 5, 5, 5};
    int dv [8] = '{4, 1, 8, 32, 64, 128, 256, 1024};
    logic [7:0] a;
    logic [7:0] d;
    for (int c = 0; c < 8; c++)
    begin
      wr(IDX_CONTROL, ctl(1'b0, WM_NORMAL, COM_OFF, c[2:0]));
      apb(1'b0, IDX_COUNT, 8'h00);
      a = rd[7:0];
      cyc(4 * dv[c]);
      apb(1'b0, IDX_COUNT, 8'h00);
      d = rd[7:0] - a;
      check((d >= lo[c]) && (d <= hi[c]), 1'b1);
    end
    wr(IDX_CONTROL, ctl(1'b0, WM_NORMAL, COM_OFF, CS_STOP));
  endtask : t_presc

  task automatic t_pwm;
    logic [1:0] md [6] = '{WM_FAST, WM_FAST, WM_FAST,
                           WM_PHASE, WM_PHASE, WM_PHASE};
    logic [1:0] cm [6] = '{COM_CLEAR, COM_SET, COM_CLEAR,
                           COM_CLEAR, COM_SET, COM_CLEAR};
    logic [7:0] cv [6] = '{8'h80, 8'h80, 8'hFF, 8'h40, 8'h40, 8'hFF};
    int         ex [6] = '{514, 506, 1020, 256, 764, 1020};
    int         hcnt;
    logic       ok;
    for (int i = 0; i < 6; i++)
    begin
      wr(IDX_CONTROL, ctl(1'b0, WM_NORMAL, COM_OFF, CS_STOP));
      wr(IDX_COMPARE, cv[i]);
      wr(IDX_COUNT, 8'h00);
      wr(IDX_CONTROL, ctl(1'b0, md[i], cm[i], CS_1));
      // First period may start from a stale level
      cyc(520);
      hcnt = 0;
      repeat (1020)
      begin
        @(posedge pclk);
        if (pin.out === 1'b1) hcnt++;
      end
      ok = (hcnt >= ex[i] - 8) && (hcnt <= ex[i] + 8);
      check(ok, 1'b1);
    end
    wr(IDX_CONTROL, ctl(1'b0, WM_NORMAL, COM_OFF, CS_STOP));
  endtask : t_pwm

  task automatic wait_idle(input int b);
    int n;
    n = 0;
    do
    begin
      apb(1'b0, IDX_ASYNC, 8'h00);
      n++;
      if (n > 50)
      begin
        fails++;
        tally_and_finish();
      end
    end while (rd[b] !== 1'b0);
  endtask : wait_idle

  task automatic t_async;
    logic [7:0] a;
    wr(IDX_ASYNC, 8'h08);
    osc_run <= 1'b1;
    wr(IDX_COUNT, 8'h33);
    apb(1'b0, IDX_ASYNC, 8'h00);
    check(rd[2], 1'b1);
    wait_idle(2);
    rdc(IDX_COUNT, 8'h33);
    wr(IDX_COMPARE, 8'h66);
    wait_idle(1);
    rdc(IDX_COMPARE, 8'h66);
    wr(IDX_CONTROL, ctl(1'b0, WM_NORMAL, COM_OFF, CS_1));
    wait_idle(0);
    osc_run <= 1'b0;
    cyc(20);
    apb(1'b0, IDX_COUNT, 8'h00);
    a = rd[7:0];
    cyc(50);
    rdc(IDX_COUNT, a);
    osc_run <= 1'b1;
    cyc(100);
    apb(1'b0, IDX_COUNT, 8'h00);
    check(rd[7:0] !== a, 1'b1);
  endtask : t_async

  initial
  begin
    fails   = 0;
    checks  = 0;
    req     = '0;
    presetn = 1'b0;
    osc_run = 1'b0;
    gie     = 1'b0;
    cack    = 1'b0;
    oack    = 1'b0;
    pdir    = 1'b0;
    pdat    = 1'b0;
    cyc(2);
    presetn <= 1'b1;
    t_regs();
    t_force();
    t_ovf();
    t_ctc();
    t_block();
    t_presc();
    t_pwm();
    t_async();
    tally_and_finish();
  end
endmodule : tmr8_timer_tb

// ==== src/tmr8_pkg.sv ====
// Purpose: constants and carriers for the 8-bit timer with compare unit
// Assumes: APB3 slave, 32-bit data, one register per aligned word
// Notes:   byte address = 4 * register index
package tmr8_pkg;
  localparam logic [5:0] IDX_CONTROL = 6'h10;
  localparam logic [5:0] IDX_COUNT   = 6'h11;
  localparam logic [5:0] IDX_COMPARE = 6'h12;
  localparam logic [5:0] IDX_MASK    = 6'h13;
  localparam logic [5:0] IDX_ASYNC   = 6'h14;
  localparam logic [5:0] IDX_FLAGS   = 6'h17;
  localparam int CTL_FORCE = 7;
  localparam int CTL_WGM0  = 6;
  localparam int CTL_WGM1  = 3;
  localparam int COM_HI    = 5;
  localparam int COM_LO    = 4;
  localparam int CS_HI     = 2;
  localparam int CS_LO     = 0;
  localparam int BIT_CMP   = 1;
  localparam int BIT_OVF   = 0;
  localparam int ASYNC_SEL = 3;
  localparam int HOLD_CNT  = 0;
  localparam int HOLD_OCR  = 1;
  localparam int HOLD_CTL  = 2;
  localparam logic [7:0] COUNT_MAX    = 8'hFF;
  localparam logic [7:0] COUNT_BOTTOM = 8'h00;
  localparam logic [7:0] RESET_BYTE   = 8'h00;
  localparam logic [1:0] COMMIT_EDGES = 2'h2;
  localparam logic [9:0] PRE_DIV1    = 10'h000;
  localparam logic [9:0] PRE_DIV8    = 10'h007;
  localparam logic [9:0] PRE_DIV32   = 10'h01F;
  localparam logic [9:0] PRE_DIV64   = 10'h03F;
  localparam logic [9:0] PRE_DIV128  = 10'h07F;
  localparam logic [9:0] PRE_DIV256  = 10'h0FF;
  localparam logic [9:0] PRE_DIV1024 = 10'h3FF;
  typedef enum logic [1:0] {
    WM_NORMAL = 2'b00,
    WM_PHASE  = 2'b01,
    WM_CTC    = 2'b10,
    WM_FAST   = 2'b11
  } tmr8_mode_e;
  typedef enum logic [1:0] {
    COM_OFF    = 2'b00,
    COM_TOGGLE = 2'b01,
    COM_CLEAR  = 2'b10,
    COM_SET    = 2'b11
  } tmr8_com_e;
  typedef enum logic [2:0] {
    CS_STOP = 3'b000, CS_1   = 3'b001, CS_8   = 3'b010, CS_32 = 3'b011,
    CS_64   = 3'b100, CS_128 = 3'b101, CS_256 = 3'b110, CS_1024 = 3'b111
  } tmr8_cs_e;
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } tmr8_apb_req_s;
  typedef struct packed {
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } tmr8_apb_rsp_s;
  typedef struct packed {
    logic out;
    logic oe;
    logic override;
  } tmr8_pin_s;
  typedef struct packed {
    logic cmp_req;
    logic ovf_req;
  } tmr8_irq_s;
endpackage : tmr8_pkg

// ==== src/tmr8_timer.sv ====
// Purpose: 8-bit timer/counter with compare unit, waveform pin, APB regs
// Assumes: port direction and data bits come from pclk-domain logic
// Notes:   oscillator pin is sampled on pclk; pclk must be much faster
//
// Added by the designer: the APB slave port.
`timescale 1ns/100ps
module tmr8_timer
  import tmr8_pkg::*;
(
  input  wire logic    pclk,
  input  wire logic    presetn,
  input  tmr8_apb_req_s apb_req,
  output tmr8_apb_rsp_s apb_rsp,
  input  wire logic    oscillator_input_pin,
  input  wire logic    global_irq_enable,
  input  wire logic    compare_vector_ack,
  input  wire logic    overflow_vector_ack,
  input  wire logic    port_direction_bit,
  input  wire logic    port_data_bit,
  output tmr8_pin_s    pin,
  output tmr8_irq_s    irq
);

  typedef struct packed {
    tmr8_apb_rsp_s   rsp;
    logic [7:0]      ctl;
    logic [7:0]      cnt;
    logic [7:0]      ocr_buf;
    logic [7:0]      ocr_act;
    logic [1:0]      mask;
    logic [1:0]      flags;
    logic            async_sel;
    logic [2:0][7:0] hold;
    logic [2:0]      busy;
    logic [2:0][1:0] edges;
    logic            osc_meta;
    logic            osc_sync;
    logic            osc_prev;
    logic [9:0]      prescale;
    logic            count_up;
    logic            block_next;
    logic            wave;
    tmr8_pin_s       pin;
    tmr8_irq_s       irq;
  } tmr8_state_s;

  tmr8_state_s s_q;
  tmr8_state_s s_d;

  logic       osc_rise;
  logic       src_tick;
  logic       tick;
  logic [9:0] pmask;
  tmr8_mode_e mode;
  tmr8_com_e  com;
  logic [7:0] top;
  logic       at_top;
  logic       match;
  logic       cmp_set;
  logic       ovf_set;
  logic       access;
  logic       done;
  logic       wr;
  logic       mapped;
  logic [5:0] idx;
  logic [7:0] rd_byte;
  logic       ctl_load;
  logic [7:0] ctl_val;
  logic       cnt_load;
  logic [7:0] cnt_val;
  logic       ocr_load;
  logic [7:0] ocr_val;
  logic       force_now;
  tmr8_com_e  force_com;
  tmr8_mode_e new_mode;
  logic [1:0] wclear;

  always_comb
  begin
    s_d       = s_q;
    ctl_load  = 1'b0;
    ctl_val   = RESET_BYTE;
    cnt_load  = 1'b0;
    cnt_val   = RESET_BYTE;
    ocr_load  = 1'b0;
    ocr_val   = RESET_BYTE;
    force_now = 1'b0;
    force_com = COM_OFF;
    new_mode  = WM_NORMAL;
    wclear    = 2'b00;
    cmp_set   = 1'b0;
    ovf_set   = 1'b0;
    rd_byte   = RESET_BYTE;

    // The first stage only feeds the second; edge detect reads the second and third stages
    s_d.osc_meta = oscillator_input_pin;
    s_d.osc_sync = s_q.osc_meta;
    s_d.osc_prev = s_q.osc_sync;
    osc_rise     = s_q.osc_sync & ~s_q.osc_prev;
    src_tick     = s_q.async_sel ? osc_rise : 1'b1;

    mode = tmr8_mode_e'({s_q.ctl[CTL_WGM1], s_q.ctl[CTL_WGM0]});
    com  = tmr8_com_e'(s_q.ctl[COM_HI:COM_LO]);

    unique case (tmr8_cs_e'(s_q.ctl[CS_HI:CS_LO]))
      CS_STOP: pmask = PRE_DIV1;
      CS_1:    pmask = PRE_DIV1;
      CS_8:    pmask = PRE_DIV8;
      CS_32:   pmask = PRE_DIV32;
      CS_64:   pmask = PRE_DIV64;
      CS_128:  pmask = PRE_DIV128;
      CS_256:  pmask = PRE_DIV256;
      CS_1024: pmask = PRE_DIV1024;
    endcase
    if (src_tick)
      s_d.prescale = s_q.prescale + 10'h001;
    tick = src_tick && (s_q.ctl[CS_HI:CS_LO] != CS_STOP) &&
           ((s_q.prescale & pmask) == pmask);

    // APB: one wait state, then pready for one cycle
    access = apb_req.psel & apb_req.penable;
    done   = access & s_q.rsp.pready;
    idx    = apb_req.paddr[7:2];
    mapped = (apb_req.paddr[11:8] == 4'h0) &&
             (apb_req.paddr[1:0] == 2'h0) &&
             (idx == IDX_CONTROL || idx == IDX_COUNT ||
              idx == IDX_COMPARE || idx == IDX_MASK ||
              idx == IDX_ASYNC || idx == IDX_FLAGS);
    wr     = done & apb_req.pwrite & mapped;
    unique case (idx)
      IDX_CONTROL:
        rd_byte = s_q.async_sel ? s_q.hold[HOLD_CTL] : s_q.ctl;
      IDX_COUNT:   rd_byte = s_q.cnt;
      IDX_COMPARE:
        rd_byte = s_q.async_sel ? s_q.hold[HOLD_OCR] : s_q.ocr_buf;
      IDX_MASK:    rd_byte = {6'h00, s_q.mask};
      IDX_ASYNC:
        rd_byte = {4'h0, s_q.async_sel, s_q.busy[HOLD_CNT],
                   s_q.busy[HOLD_OCR], s_q.busy[HOLD_CTL]};
      IDX_FLAGS:   rd_byte = {6'h00, s_q.flags};
      default:     rd_byte = RESET_BYTE;
    endcase
    if (idx == IDX_CONTROL)
      rd_byte[CTL_FORCE] = 1'b0;
    s_d.rsp.pready = access & ~s_q.rsp.pready;
    if (access & ~s_q.rsp.pready)
    begin
      s_d.rsp.prdata  = {24'h000000, rd_byte};
      s_d.rsp.pslverr = ~mapped;
    end

    // Holding registers commit on the second oscillator edge
    for (int i = 0; i < 3; i++)
    begin
      if (s_q.busy[i] && osc_rise)
      begin
        s_d.edges[i] = s_q.edges[i] + 2'h1;
        if (s_q.edges[i] == COMMIT_EDGES - 2'h1)
        begin
          s_d.busy[i]  = 1'b0;
          s_d.edges[i] = 2'h0;
        end
      end
    end
    if (s_q.busy[HOLD_CNT] && osc_rise && s_q.edges[HOLD_CNT] == 2'h1)
    begin
      cnt_load = 1'b1;
      cnt_val  = s_q.hold[HOLD_CNT];
    end
    if (s_q.busy[HOLD_OCR] && osc_rise && s_q.edges[HOLD_OCR] == 2'h1)
    begin
      ocr_load = 1'b1;
      ocr_val  = s_q.hold[HOLD_OCR];
    end
    if (s_q.busy[HOLD_CTL] && osc_rise && s_q.edges[HOLD_CTL] == 2'h1)
    begin
      ctl_load = 1'b1;
      ctl_val  = s_q.hold[HOLD_CTL];
    end

    if (wr)
    begin
      unique case (idx)
        IDX_CONTROL:
          if (s_q.async_sel)
          begin
            s_d.hold[HOLD_CTL]  = apb_req.pwdata[7:0];
            s_d.busy[HOLD_CTL]  = 1'b1;
            s_d.edges[HOLD_CTL] = 2'h0;
          end
          else
          begin
            ctl_load = 1'b1;
            ctl_val  = apb_req.pwdata[7:0];
          end
        IDX_COUNT:
          if (s_q.async_sel)
          begin
            s_d.hold[HOLD_CNT]  = apb_req.pwdata[7:0];
            s_d.busy[HOLD_CNT]  = 1'b1;
            s_d.edges[HOLD_CNT] = 2'h0;
          end
          else
          begin
            cnt_load = 1'b1;
            cnt_val  = apb_req.pwdata[7:0];
          end
        IDX_COMPARE:
          if (s_q.async_sel)
          begin
            s_d.hold[HOLD_OCR]  = apb_req.pwdata[7:0];
            s_d.busy[HOLD_OCR]  = 1'b1;
            s_d.edges[HOLD_OCR] = 2'h0;
          end
          else
          begin
            ocr_load = 1'b1;
            ocr_val  = apb_req.pwdata[7:0];
          end
        IDX_MASK:  s_d.mask = apb_req.pwdata[1:0];
        IDX_ASYNC: s_d.async_sel = apb_req.pwdata[ASYNC_SEL];
        IDX_FLAGS: wclear = apb_req.pwdata[1:0];
        default:   s_d.mask = s_q.mask;
      endcase
    end

    // Counter sequence
    top    = (mode == WM_CTC) ? s_q.ocr_act : COUNT_MAX;
    at_top = tick && (s_q.cnt == top);
    match  = tick && (s_q.cnt == s_q.ocr_act) && !s_q.block_next;
    if (tick)
      s_d.block_next = 1'b0;
    if (tick)
    begin
      if (mode == WM_PHASE)
      begin
        if (s_q.count_up)
        begin
          if (s_q.cnt == COUNT_MAX)
          begin
            s_d.count_up = 1'b0;
            s_d.cnt      = s_q.cnt - 8'h01;
            s_d.ocr_act  = s_q.ocr_buf;
          end
          else
            s_d.cnt = s_q.cnt + 8'h01;
        end
        else if (s_q.cnt == COUNT_BOTTOM)
        begin
          s_d.count_up = 1'b1;
          s_d.cnt      = s_q.cnt + 8'h01;
          ovf_set      = 1'b1;
        end
        else
          s_d.cnt = s_q.cnt - 8'h01;
      end
      else
      begin
        s_d.count_up = 1'b1;
        s_d.cnt = at_top ? COUNT_BOTTOM : s_q.cnt + 8'h01;
        ovf_set = (s_q.cnt == COUNT_MAX);
        if (at_top && mode == WM_FAST)
          s_d.ocr_act = s_q.ocr_buf;
      end
    end
    cmp_set = match;

    // Waveform unit
    unique case (mode)
      WM_NORMAL, WM_CTC:
        if (match)
          unique case (com)
            COM_OFF:    s_d.wave = s_q.wave;
            COM_TOGGLE: s_d.wave = ~s_q.wave;
            COM_CLEAR:  s_d.wave = 1'b0;
            COM_SET:    s_d.wave = 1'b1;
          endcase
      WM_FAST:
        if (com[1])
        begin
          // A match at top loses to the bottom level
          if (at_top)
            s_d.wave = ~com[0];
          else if (match)
            s_d.wave = com[0];
        end
      WM_PHASE:
        if (com[1])
        begin
          if (s_q.ocr_act == COUNT_MAX)
          begin
            if (tick && s_q.count_up && s_q.cnt == COUNT_MAX)
              s_d.wave = ~com[0];
          end
          else if (match)
            s_d.wave = s_q.count_up ? com[0] : ~com[0];
        end
    endcase

    if (ctl_load)
    begin
      s_d.ctl            = ctl_val;
      s_d.ctl[CTL_FORCE] = 1'b0;
      new_mode = tmr8_mode_e'({ctl_val[CTL_WGM1], ctl_val[CTL_WGM0]});
      force_com = tmr8_com_e'(ctl_val[COM_HI:COM_LO]);
      force_now = ctl_val[CTL_FORCE] &&
                  (new_mode == WM_NORMAL || new_mode == WM_CTC);
    end
    // Force touches only the output, never flag or counter
    if (force_now)
      unique case (force_com)
        COM_OFF:    s_d.wave = s_d.wave;
        COM_TOGGLE: s_d.wave = ~s_q.wave;
        COM_CLEAR:  s_d.wave = 1'b0;
        COM_SET:    s_d.wave = 1'b1;
      endcase

    if (cnt_load)
    begin
      s_d.cnt        = cnt_val;
      s_d.block_next = 1'b1;
    end
    if (ocr_load)
    begin
      s_d.ocr_buf = ocr_val;
      new_mode = tmr8_mode_e'({s_d.ctl[CTL_WGM1], s_d.ctl[CTL_WGM0]});
      if (new_mode == WM_NORMAL || new_mode == WM_CTC)
        s_d.ocr_act = ocr_val;
    end

    // Hardware set wins over any clear in the same cycle
    s_d.flags[BIT_CMP] = cmp_set | (s_q.flags[BIT_CMP] &
                         ~(wclear[BIT_CMP] | compare_vector_ack));
    s_d.flags[BIT_OVF] = ovf_set | (s_q.flags[BIT_OVF] &
                         ~(wclear[BIT_OVF] | overflow_vector_ack));
    s_d.irq.cmp_req = s_q.mask[BIT_CMP] & global_irq_enable &
                      s_q.flags[BIT_CMP];
    s_d.irq.ovf_req = s_q.mask[BIT_OVF] & global_irq_enable &
                      s_q.flags[BIT_OVF];

    s_d.pin.override = (s_d.ctl[COM_HI:COM_LO] != COM_OFF);
    s_d.pin.out      = s_d.pin.override ? s_d.wave : port_data_bit;
    s_d.pin.oe       = port_direction_bit;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign apb_rsp = s_q.rsp;
  assign pin     = s_q.pin;
  assign irq     = s_q.irq;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  force_reads_zero_a: assert property (
    apb_rsp.pready && apb_req.psel && !apb_req.pwrite &&
    idx == IDX_CONTROL |-> apb_rsp.prdata[CTL_FORCE] == 1'b0)
    else $error("force strobe read back as one");
  force_no_flag_a: assert property (
    force_now && !cmp_set |=> !$rose(s_q.flags[BIT_CMP]))
    else $error("forced compare set the compare flag");
  force_no_clear_a: assert property (
    force_now && !tick && !cnt_load |=> s_q.cnt == $past(s_q.cnt))
    else $error("forced compare changed the counter");
  force_set_a: assert property (
    force_now && force_com == COM_SET |=> s_q.wave ##1 pin.out)
    else $error("forced set did not reach the pin");
  pin_follows_a: assert property (
    pin.override |-> pin.out == s_q.wave)
    else $error("pin not driven by waveform");
  cmp_irq_a: assert property (
    irq.cmp_req |-> $past(s_q.mask[BIT_CMP] && global_irq_enable &&
                          s_q.flags[BIT_CMP]))
    else $error("compare request without cause");
  ovf_irq_a: assert property (
    irq.ovf_req |-> $past(s_q.mask[BIT_OVF] && global_irq_enable &&
                          s_q.flags[BIT_OVF]))
    else $error("overflow request without cause");
  set_wins_a: assert property (
    cmp_set |=> s_q.flags[BIT_CMP])
    else $error("compare flag lost on match");
  normal_wrap_a: assert property (
    tick && mode == WM_NORMAL && s_q.cnt == COUNT_MAX && !cnt_load
    |=> s_q.cnt == COUNT_BOTTOM && s_q.flags[BIT_OVF])
    else $error("normal mode wrap wrong");
  phase_ovf_a: assert property (
    tick && mode == WM_PHASE && !s_q.count_up &&
    s_q.cnt == COUNT_BOTTOM |=> s_q.flags[BIT_OVF] && s_q.count_up)
    else $error("phase mode overflow at bottom missing");
  write_block_a: assert property (
    s_q.block_next && tick |-> !cmp_set)
    else $error("match not blocked after counter write");
  stopped_a: assert property (
    s_q.ctl[CS_HI:CS_LO] == CS_STOP |-> !tick)
    else $error("stopped timer ticked");

endmodule : tmr8_timer
